// ==== design/rtc_bus_pin_ctrl.v ====
`timescale 1ns/10ps
`default_nettype none
`include "rtc_pin_map.vh"
module rtc_bus_pin_ctrl #(
  parameter RAM_BYTES = `RTC_RAM_BYTES,
  parameter RECOVERY_CYCLES = `RTC_RECOVERY_CYCLES
) (
  // clock and reset
  input wire clk_sys,
  input wire reset,
  // shared address/data bus and strobes
  input wire [7:0] sharedBusIn,
  output reg [7:0] sharedBusOut_ff,
  output reg sharedBusOe_n_ff,
  input wire addrLatchStrobe,
  input wire chipSelect_n,
  input wire readStrobe_n,
  input wire writeStrobe_n,
  // open-drain outputs, pin level is low whenever enabled
  output reg irqOe_n_ff,
  output reg powerOnOe_n_ff,
  // other pins
  input wire kickstart_in_n,
  input wire ram_clear_in_n,
  output reg square_wave_out_ff,
  // supply monitors and crystal clock
  input wire mainSupplyOk,
  input wire aux_battery_supply,
  input wire crystalClk
);
  localparam I_ALE = 8;
  localparam I_CSN = 9;
  localparam I_RDN = 10;
  localparam I_WRN = 11;
  localparam I_KSN = 12;
  localparam I_RCLRN = 13;
  localparam I_MAIN = 14;
  localparam I_AUX = 15;
  localparam I_XTAL = 16;
  // counter is 12 bits and clear index 7 bits; the cut to those widths is deliberate
  localparam integer RECOVERY_INT = RECOVERY_CYCLES;
  localparam integer RAM_LAST_INT = RAM_BYTES - 1;
  localparam [11:0] RECOVERY_LOAD = RECOVERY_INT[11:0];
  localparam [6:0] RAM_LAST = RAM_LAST_INT[6:0];

  reg [16:0] sync1_ff, sync2_ff, prev_ff;
  reg [11:0] recoverCnt_ff;
  reg accessible_ff, powerUp_ff;
  reg [7:0] addrLatch_ff, wrData_ff;
  reg csHeld_ff, readFlags_ff, tickDly_ff, tapPrev_ff, powerActive_ff;
  reg clearing_ff;
  reg [6:0] clearIdx_ff;
  reg [14:0] divider_ff;
  reg [7:0] ctrlA_ff, ctrlB_ff, extCtrl_ff, powerCtrl_ff;
  reg [7:0] sec_ff, min_ff, hour_ff, date_ff, month_ff, year_ff;
  reg [7:0] secAl_ff, minAl_ff, hourAl_ff;
  reg [7:0] flags_ff;
  reg kickFlag_ff, wakeFlag_ff;
  reg [7:0] readValue;
  wire [7:0] ramRdData;

  // days in a month; a two-digit year divisible by four is leap, right for 2000-2099
  function [7:0] daysIn;
    input [7:0] m;
    input [7:0] y;
    begin
      case (m)
        8'h02: daysIn = (y[1:0] == 2'h0) ? 8'h1d : 8'h1c;
        8'h04, 8'h06, 8'h09, 8'h0b: daysIn = 8'h1e;
        default: daysIn = 8'h1f;
      endcase
    end
  endfunction

  // alarm byte with both top bits set matches anything
  function alarmHit;
    input [7:0] al;
    input [7:0] v;
    begin
      alarmHit = (al[7:6] == 2'h3) || (al == v);
    end
  endfunction

  // square-wave tap for a rate code, zero means no tap
  function tapOf;
    input [3:0] rate;
    input [14:0] div;
    begin
      case (rate)
        4'h0: tapOf = 1'b0;
        4'h1: tapOf = div[6];
        4'h2: tapOf = div[7];
        default: tapOf = div[rate - 4'h2];
      endcase
    end
  endfunction

  // ram region: 0e..3f in both banks, 40..7f only in bank 0
  function isRam;
    input [7:0] a;
    input bank;
    begin
      isRam = (a >= `RTC_ADDR_RAM_FIRST) && (a < `RTC_ADDR_BANK1_FIRST ||
              (!bank && a < `RTC_ADDR_RAM_END));
    end
  endfunction

  wire [7:0] busIn = sync2_ff[7:0];
  wire mainOk = sync2_ff[I_MAIN];
  wire auxOk = sync2_ff[I_AUX];
  wire xtal = sync2_ff[I_XTAL];
  wire xtalRise = xtal && !prev_ff[I_XTAL];
  wire aleFall = !sync2_ff[I_ALE] && prev_ff[I_ALE];
  wire wrLow = !sync2_ff[I_WRN];
  wire wrFall = wrLow && prev_ff[I_WRN];
  wire wrRise = !wrLow && !prev_ff[I_WRN];
  wire rdRise = sync2_ff[I_RDN] && !prev_ff[I_RDN];
  wire csLow = !sync2_ff[I_CSN];
  wire kickFall = !sync2_ff[I_KSN] && prev_ff[I_KSN];
  wire rclrFall = !sync2_ff[I_RCLRN] && prev_ff[I_RCLRN];
  wire mainRise = mainOk && !prev_ff[I_MAIN];
  wire bank1 = ctrlA_ff[`RTC_A_BANK];
  wire abe = extCtrl_ff[`RTC_X_ABE];
  wire fast_clock_out_enable = extCtrl_ff[`RTC_X_FAST_CLOCK_OUT_ENABLE];
  wire divRun = ctrlA_ff[`RTC_A_DV1] && !ctrlA_ff[`RTC_A_DV2];
  wire secTick = xtalRise && divRun && (divider_ff == 15'h7fff);
  wire tap = tapOf(ctrlA_ff[3:0], divider_ff);
  wire wrCommit = wrRise && csHeld_ff && accessible_ff;
  wire rdActive = !sync2_ff[I_RDN] && csLow && accessible_ff;
  wire wrPower = wrCommit && bank1 && addrLatch_ff == `RTC_ADDR_POWER_CTRL;
  wire alarmMatch = tickDly_ff && alarmHit(secAl_ff, sec_ff) &&
                    alarmHit(minAl_ff, min_ff) && alarmHit(hourAl_ff, hour_ff);
  wire wakeEvent = alarmMatch && powerCtrl_ff[`RTC_P_WAKE_IE];
  wire batteryOk = auxOk && abe;
  wire [7:0] ramRdAddr = addrLatch_ff - `RTC_ADDR_RAM_FIRST;
  wire ramWrEn = clearing_ff || (wrCommit && isRam(addrLatch_ff, bank1));

  // two flip-flops on every pin input, a third stage for edge detection
  always @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      sync1_ff <= 17'h03e00; // idle pin levels, so no false strobe edge follows reset
      sync2_ff <= 17'h03e00;
      prev_ff <= 17'h03e00;
    end
    else
    begin
      sync1_ff <= {crystalClk, aux_battery_supply, mainSupplyOk, ram_clear_in_n, kickstart_in_n,
                   writeStrobe_n, readStrobe_n, chipSelect_n, addrLatchStrobe, sharedBusIn};
      sync2_ff <= sync1_ff;
      prev_ff <= sync2_ff;
    end
  end

  // power-up detection and recovery delay before the bus opens
  always @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      recoverCnt_ff <= 12'h000;
      accessible_ff <= 1'b0;
      powerUp_ff <= 1'b0;
    end
    else
    begin
      powerUp_ff <= mainRise;
      if (!mainOk)
      begin
        accessible_ff <= 1'b0;
        recoverCnt_ff <= 12'h000;
      end
      else if (mainRise)
        recoverCnt_ff <= RECOVERY_LOAD;
      else if (recoverCnt_ff != 12'h000)
        recoverCnt_ff <= recoverCnt_ff - 12'h001;
      else
        accessible_ff <= 1'b1;
    end
  end

  // address latch, write data capture and chip-select tracking
  always @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      addrLatch_ff <= 8'h00;
      wrData_ff <= 8'h00;
      csHeld_ff <= 1'b0;
      readFlags_ff <= 1'b0;
    end
    else
    begin
      if (aleFall && accessible_ff)
        addrLatch_ff <= busIn;
      if (wrLow)
        wrData_ff <= busIn;
      if (wrFall)
        csHeld_ff <= csLow;
      else if (wrLow && !csLow)
        csHeld_ff <= 1'b0;
      if (rdActive && addrLatch_ff == `RTC_ADDR_FLAGS)
        readFlags_ff <= 1'b1;
      else if (rdRise)
        readFlags_ff <= 1'b0;
    end
  end

  // divider chain: 15 stages clocked by the crystal edge
  always @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      divider_ff <= 15'h0000;
      tapPrev_ff <= 1'b0;
      tickDly_ff <= 1'b0;
    end
    else
    begin
      if (ctrlA_ff[`RTC_A_DV2])
        divider_ff <= 15'h0000;
      else if (xtalRise && divRun)
        divider_ff <= divider_ff + 15'h0001;
      tapPrev_ff <= tap;
      tickDly_ff <= secTick;
    end
  end

  // control, time and alarm registers; a bus write beats a calendar step
  always @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      ctrlA_ff <= `RTC_RST_CTRL_A;
      ctrlB_ff <= `RTC_RST_CTRL_B;
      extCtrl_ff <= `RTC_RST_EXT_CTRL;
      powerCtrl_ff <= `RTC_RST_POWER_CTRL;
      sec_ff <= 8'h00;
      min_ff <= 8'h00;
      hour_ff <= 8'h00;
      date_ff <= 8'h01;
      month_ff <= 8'h01;
      year_ff <= 8'h00;
      secAl_ff <= 8'h00;
      minAl_ff <= 8'h00;
      hourAl_ff <= 8'h00;
    end
    else
    begin
      if (powerUp_ff)
      begin
        ctrlA_ff[`RTC_A_DV1] <= 1'b1;
        extCtrl_ff[`RTC_X_FAST_CLOCK_OUT_ENABLE] <= 1'b1;
      end
      if (secTick)
      begin
        sec_ff <= (sec_ff == 8'h3b) ? 8'h00 : sec_ff + 8'h01;
        if (sec_ff == 8'h3b)
        begin
          min_ff <= (min_ff == 8'h3b) ? 8'h00 : min_ff + 8'h01;
          if (min_ff == 8'h3b)
          begin
            hour_ff <= (hour_ff == 8'h17) ? 8'h00 : hour_ff + 8'h01;
            if (hour_ff == 8'h17)
            begin
              if (date_ff >= daysIn(month_ff, year_ff))
              begin
                date_ff <= 8'h01;
                month_ff <= (month_ff >= 8'h0c) ? 8'h01 : month_ff + 8'h01;
                if (month_ff >= 8'h0c)
                  year_ff <= (year_ff >= 8'h63) ? 8'h00 : year_ff + 8'h01;
              end
              else
                date_ff <= date_ff + 8'h01;
            end
          end
        end
      end
      if (wrCommit)
      begin
        case (addrLatch_ff)
          `RTC_ADDR_SECONDS: sec_ff <= wrData_ff;
          `RTC_ADDR_SEC_ALARM: secAl_ff <= wrData_ff;
          `RTC_ADDR_MINUTES: min_ff <= wrData_ff;
          `RTC_ADDR_MIN_ALARM: minAl_ff <= wrData_ff;
          `RTC_ADDR_HOURS: hour_ff <= wrData_ff;
          `RTC_ADDR_HOUR_ALARM: hourAl_ff <= wrData_ff;
          `RTC_ADDR_DATE: date_ff <= wrData_ff;
          `RTC_ADDR_MONTH: month_ff <= wrData_ff;
          `RTC_ADDR_YEAR: year_ff <= wrData_ff;
          `RTC_ADDR_CTRL_A: ctrlA_ff <= {1'b0, wrData_ff[6:0]};
          `RTC_ADDR_CTRL_B: ctrlB_ff <= wrData_ff;
          `RTC_ADDR_POWER_CTRL: if (bank1) powerCtrl_ff <= {1'b0, 2'h0, wrData_ff[4:2], 2'h0};
          `RTC_ADDR_EXT_CTRL: if (bank1) extCtrl_ff <= {wrData_ff[7:6], 6'h00};
          default: ;
        endcase
      end
    end
  end

  // sticky flags: a set in the same cycle as its clear wins
  always @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      flags_ff <= 8'h00;
      kickFlag_ff <= 1'b0;
      wakeFlag_ff <= 1'b0;
    end
    else
    begin
      flags_ff[`RTC_F_UPDATE] <= secTick ||
        (flags_ff[`RTC_F_UPDATE] && !(readFlags_ff && rdRise));
      flags_ff[`RTC_F_ALARM] <= alarmMatch ||
        (flags_ff[`RTC_F_ALARM] && !(readFlags_ff && rdRise));
      flags_ff[`RTC_F_PERIODIC] <= (tap && !tapPrev_ff) ||
        (flags_ff[`RTC_F_PERIODIC] && !(readFlags_ff && rdRise));
      kickFlag_ff <= kickFall || (kickFlag_ff && !(wrPower && !wrData_ff[`RTC_P_KICK_FLAG]));
      wakeFlag_ff <= wakeEvent || (wakeFlag_ff && !(wrPower && !wrData_ff[`RTC_P_WAKE_FLAG]));
    end
  end

  // power pin: hardware turns it on without main supply, software after
  always @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      powerActive_ff <= 1'b0;
    else if (!mainOk)
    begin
      if ((kickFall || wakeEvent) && batteryOk)
        powerActive_ff <= 1'b1;
    end
    else if (wrPower)
      powerActive_ff <= wrData_ff[`RTC_P_POWER_ON];
  end

  // ram clear walks every byte; bus writes to ram are dropped meanwhile
  always @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      clearing_ff <= 1'b0;
      clearIdx_ff <= 7'h00;
    end
    else if (clearing_ff)
    begin
      clearIdx_ff <= clearIdx_ff + 7'h01;
      if (clearIdx_ff == RAM_LAST)
        clearing_ff <= 1'b0;
    end
    else if (rclrFall && powerCtrl_ff[`RTC_P_RAM_CLR_EN])
    begin
      clearing_ff <= 1'b1;
      clearIdx_ff <= 7'h00;
    end
  end

  rtc_user_ram #(.WIDTH(8), .DEPTH(RAM_BYTES), .AW(7)) userRam (
    .clk_sys(clk_sys),
    .wrEn(ramWrEn),
    .wrAddr(clearing_ff ? clearIdx_ff : ramRdAddr[6:0]),
    .wrData(clearing_ff ? 8'h00 : wrData_ff),
    .rdAddr(ramRdAddr[6:0]),
    .rdData(ramRdData)
  );

  // read data for the latched address; unmapped reads as zero
  always @*
  begin
    readValue = 8'h00;
    if (isRam(addrLatch_ff, bank1))
      readValue = ramRdData;
    else
      case (addrLatch_ff)
        `RTC_ADDR_SECONDS: readValue = sec_ff;
        `RTC_ADDR_SEC_ALARM: readValue = secAl_ff;
        `RTC_ADDR_MINUTES: readValue = min_ff;
        `RTC_ADDR_MIN_ALARM: readValue = minAl_ff;
        `RTC_ADDR_HOURS: readValue = hour_ff;
        `RTC_ADDR_HOUR_ALARM: readValue = hourAl_ff;
        `RTC_ADDR_DATE: readValue = date_ff;
        `RTC_ADDR_MONTH: readValue = month_ff;
        `RTC_ADDR_YEAR: readValue = year_ff;
        `RTC_ADDR_CTRL_A: readValue = ctrlA_ff;
        `RTC_ADDR_CTRL_B: readValue = ctrlB_ff;
        `RTC_ADDR_FLAGS: readValue = {!irqOe_n_ff, flags_ff[6:0]};
        `RTC_ADDR_POWER_CTRL: readValue = bank1 ? {powerActive_ff, 2'h0,
          powerCtrl_ff[4:2], wakeFlag_ff, kickFlag_ff} : 8'h00;
        `RTC_ADDR_EXT_CTRL: readValue = bank1 ? extCtrl_ff : 8'h00;
        default: readValue = 8'h00;
      endcase
  end

  // pin outputs, all registered
  always @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      sharedBusOut_ff <= 8'h00;
      sharedBusOe_n_ff <= 1'b1;
      irqOe_n_ff <= 1'b1;
      powerOnOe_n_ff <= 1'b1;
      square_wave_out_ff <= 1'b0;
    end
    else
    begin
      sharedBusOut_ff <= readValue;
      sharedBusOe_n_ff <= !rdActive;
      // interrupt released while main supply is down, like other bus-side pins
      irqOe_n_ff <= !(mainOk && ((|(flags_ff[6:4] & ctrlB_ff[6:4])) ||
        (kickFlag_ff && powerCtrl_ff[`RTC_P_KICK_IE]) ||
        (wakeFlag_ff && powerCtrl_ff[`RTC_P_WAKE_IE])));
      powerOnOe_n_ff <= !powerActive_ff;
      if (!mainOk)
        square_wave_out_ff <= fast_clock_out_enable && batteryOk && xtal;
      else if (!accessible_ff)
        square_wave_out_ff <= 1'b0;
      else if (fast_clock_out_enable)
        square_wave_out_ff <= xtal;
      else
        square_wave_out_ff <= ctrlB_ff[`RTC_B_SQUARE_WAVE_ENABLE] && tap;
    end
  end
endmodule // rtc_bus_pin_ctrl
`default_nettype wire

// ==== design/rtc_pin_map.vh ====
`ifndef RTC_PIN_MAP_VH
`define RTC_PIN_MAP_VH
// register addresses on the shared bus
`define RTC_ADDR_SECONDS 8'h00
`define RTC_ADDR_SEC_ALARM 8'h01
`define RTC_ADDR_MINUTES 8'h02
`define RTC_ADDR_MIN_ALARM 8'h03
`define RTC_ADDR_HOURS 8'h04
`define RTC_ADDR_HOUR_ALARM 8'h05
`define RTC_ADDR_DATE 8'h07
`define RTC_ADDR_MONTH 8'h08
`define RTC_ADDR_YEAR 8'h09
`define RTC_ADDR_CTRL_A 8'h0a
`define RTC_ADDR_CTRL_B 8'h0b
`define RTC_ADDR_FLAGS 8'h0c
`define RTC_ADDR_RAM_FIRST 8'h0e
`define RTC_ADDR_BANK1_FIRST 8'h40
`define RTC_ADDR_RAM_END 8'h80
`define RTC_ADDR_POWER_CTRL 8'h4a
`define RTC_ADDR_EXT_CTRL 8'h4b
`define RTC_RAM_BYTES 114
// control register a fields
`define RTC_A_BANK 4
`define RTC_A_DV1 5
`define RTC_A_DV2 6
// control register b fields: interrupt enables line up with flag bits
`define RTC_B_SQUARE_WAVE_ENABLE 3
`define RTC_F_UPDATE 4
`define RTC_F_ALARM 5
`define RTC_F_PERIODIC 6
`define RTC_F_ANY 7
// power control register fields
`define RTC_P_KICK_FLAG 0
`define RTC_P_WAKE_FLAG 1
`define RTC_P_KICK_IE 2
`define RTC_P_WAKE_IE 3
`define RTC_P_RAM_CLR_EN 4
`define RTC_P_POWER_ON 7
// extended control register fields
`define RTC_X_FAST_CLOCK_OUT_ENABLE 6
`define RTC_X_ABE 7
// reset values
`define RTC_RST_CTRL_A 8'h00
`define RTC_RST_CTRL_B 8'h00
`define RTC_RST_EXT_CTRL 8'h00
`define RTC_RST_POWER_CTRL 8'h00
// timing
`define RTC_CLK_KHZ 10000
`define RTC_RECOVERY_DELAY_US 200
`define RTC_RECOVERY_CYCLES ((`RTC_RECOVERY_DELAY_US * `RTC_CLK_KHZ + 999) / 1000)
`endif

// ==== design/rtc_user_ram.v ====
`timescale 1ns/10ps
`default_nettype none
// user ram with one write port and a registered read port
module rtc_user_ram #(
  parameter WIDTH = 8,
  parameter DEPTH = 114,
  parameter AW = 7
) (
  // clock
  input wire clk_sys,
  // write port
  input wire wrEn,
  input wire [AW-1:0] wrAddr,
  input wire [WIDTH-1:0] wrData,
  // read port
  input wire [AW-1:0] rdAddr,
  output reg [WIDTH-1:0] rdData
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];

  // no reset on the array: contents are kept as if battery backed
  always @(posedge clk_sys)
  begin
    if (wrEn && wrAddr < DEPTH)
      mem[wrAddr] <= wrData;
    rdData <= (rdAddr < DEPTH) ? mem[rdAddr] : {WIDTH{1'b0}};
  end
endmodule // rtc_user_ram
`default_nettype wire

// ==== tb/rtc_bus_pin_chk.sv ====
`timescale 1ns/10ps
`default_nettype none
module rtc_bus_pin_chk #(
  parameter RAM_BYTES = 114,
  parameter RECOVERY_CYCLES = 2000
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // bus pins
  input wire logic [7:0] sharedBusIn,
  input wire logic [7:0] sharedBusOut_ff,
  input wire logic sharedBusOe_n_ff,
  input wire logic addrLatchStrobe,
  input wire logic chipSelect_n,
  input wire logic readStrobe_n,
  input wire logic writeStrobe_n,
  // other pins
  input wire logic irqOe_n_ff,
  input wire logic powerOnOe_n_ff,
  input wire logic kickstart_in_n,
  input wire logic ram_clear_in_n,
  input wire logic square_wave_out_ff,
  input wire logic mainSupplyOk,
  input wire logic aux_battery_supply,
  input wire logic crystalClk
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  // bus drive follows the read strobe, with sync latency margin
  bus_release_a: assert property ($rose(readStrobe_n) |-> ##[1:5] sharedBusOe_n_ff)
    else $error("bus still driven after read");
  no_select_a: assert property ((readStrobe_n || chipSelect_n) [*6] |-> sharedBusOe_n_ff)
    else $error("bus driven without select and read");
  read_cause_a: assert property ($fell(sharedBusOe_n_ff) |-> !$past(readStrobe_n, 2) && !$past(chipSelect_n, 2))
    else $error("bus drive without read cycle");
  // power fail leaves bus and interrupt released
  mainoff_bus_a: assert property ((!mainSupplyOk) [*6] |-> sharedBusOe_n_ff)
    else $error("bus driven in power fail");
  mainoff_irq_a: assert property ((!mainSupplyOk) [*6] |-> irqOe_n_ff)
    else $error("interrupt low in power fail");
  kick_aux_a: assert property (!mainSupplyOk && $fell(powerOnOe_n_ff) |-> $past(aux_battery_supply, 3))
    else $error("power on without aux supply");
  sqw_dead_a: assert property ((!mainSupplyOk && !aux_battery_supply) [*8] |=> $stable(square_wave_out_ff))
    else $error("square wave with no supply");
  // reset has no disable so it is checked while reset is high
  reset_idle_a: assert property (@(posedge clk_sys) disable iff (1'b0)
    reset |-> sharedBusOe_n_ff && irqOe_n_ff && powerOnOe_n_ff && !square_wave_out_ff)
    else $error("outputs active in reset");
  cover property (!sharedBusOe_n_ff);
  cover property (!irqOe_n_ff);
  cover property (!powerOnOe_n_ff && !mainSupplyOk);
endmodule // rtc_bus_pin_chk
bind rtc_bus_pin_ctrl rtc_bus_pin_chk #(.RAM_BYTES(RAM_BYTES), .RECOVERY_CYCLES(RECOVERY_CYCLES)) i_chk (
  .clk_sys(clk_sys), .reset(reset), .sharedBusIn(sharedBusIn), .sharedBusOut_ff(sharedBusOut_ff),
  .sharedBusOe_n_ff(sharedBusOe_n_ff), .addrLatchStrobe(addrLatchStrobe), .chipSelect_n(chipSelect_n),
  .readStrobe_n(readStrobe_n), .writeStrobe_n(writeStrobe_n), .irqOe_n_ff(irqOe_n_ff),
  .powerOnOe_n_ff(powerOnOe_n_ff), .kickstart_in_n(kickstart_in_n), .ram_clear_in_n(ram_clear_in_n),
  .square_wave_out_ff(square_wave_out_ff), .mainSupplyOk(mainSupplyOk),
  .aux_battery_supply(aux_battery_supply), .crystalClk(crystalClk));
`default_nettype wire

// ==== tb/rtc_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module rtc_host_model (
  // clock and bus level
  input wire logic clk_sys,
  input wire logic [7:0] busWire,
  // strobes and bus drive
  output logic addrLatchStrobe,
  output logic chipSelect_n,
  output logic readStrobe_n,
  output logic writeStrobe_n,
  output logic busEn,
  output logic [7:0] busDrv
);
  // idle bus: nothing selected, nothing driven
  initial
  begin
    addrLatchStrobe = 1'b0;
    chipSelect_n = 1'b1;
    readStrobe_n = 1'b1;
    writeStrobe_n = 1'b1;
    busEn = 1'b0;
    busDrv = 8'h00;
  end
  task automatic waitc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // address held over the whole strobe, well past the sync delay
  task automatic latch(input logic [7:0] a);
    busEn <= 1'b1;
    busDrv <= a;
    addrLatchStrobe <= 1'b1;
    waitc(6);
    addrLatchStrobe <= 1'b0;
    waitc(6);
  endtask
  // select spans the strobe; data stable before the strobe ends
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic sel);
    latch(a);
    chipSelect_n <= !sel;
    writeStrobe_n <= 1'b0;
    busDrv <= d;
    waitc(8);
    writeStrobe_n <= 1'b1;
    waitc(5);
    chipSelect_n <= 1'b1;
    busEn <= 1'b0;
    waitc(4);
  endtask
  task automatic strobeRd(output logic [7:0] d);
    busEn <= 1'b0;
    chipSelect_n <= 1'b0;
    readStrobe_n <= 1'b0;
    waitc(8);
    d = busWire;
    readStrobe_n <= 1'b1;
    waitc(5);
    chipSelect_n <= 1'b1;
    waitc(4);
  endtask
endmodule // rtc_host_model
`default_nettype wire

// ==== tb/tb_rtc_bus_pin_ctrl.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_rtc_bus_pin_ctrl;
  logic clk_sys, reset, crystalClk, mainSupplyOk, aux_battery_supply, kickstart_in_n, ram_clear_in_n;
  logic addrLatchStrobe, chipSelect_n, readStrobe_n, writeStrobe_n, busEn;
  logic [7:0] busDrv, busWire, sharedBusOut_ff, d;
  logic [7:0] noise_ff = 8'h00;
  logic sharedBusOe_n_ff, irqOe_n_ff, powerOnOe_n_ff, square_wave_out_ff;
  logic sqPrev_ff = 1'b0;
  int error_cnt = 0, checks = 0, sqEdges = 0, c;
  // undriven bus shows a changing pattern, never a held value
  assign busWire = !sharedBusOe_n_ff ? sharedBusOut_ff : (busEn ? busDrv : noise_ff);
  rtc_bus_pin_ctrl #(.RECOVERY_CYCLES(8)) i_dut (
    .clk_sys(clk_sys), .reset(reset), .sharedBusIn(busWire), .sharedBusOut_ff(sharedBusOut_ff),
    .sharedBusOe_n_ff(sharedBusOe_n_ff), .addrLatchStrobe(addrLatchStrobe), .chipSelect_n(chipSelect_n),
    .readStrobe_n(readStrobe_n), .writeStrobe_n(writeStrobe_n), .irqOe_n_ff(irqOe_n_ff),
    .powerOnOe_n_ff(powerOnOe_n_ff), .kickstart_in_n(kickstart_in_n), .ram_clear_in_n(ram_clear_in_n),
    .square_wave_out_ff(square_wave_out_ff), .mainSupplyOk(mainSupplyOk),
    .aux_battery_supply(aux_battery_supply), .crystalClk(crystalClk));
  rtc_host_model i_host (
    .clk_sys(clk_sys), .busWire(busWire), .addrLatchStrobe(addrLatchStrobe), .chipSelect_n(chipSelect_n),
    .readStrobe_n(readStrobe_n), .writeStrobe_n(writeStrobe_n), .busEn(busEn), .busDrv(busDrv));
  // 10 mhz system clock and an unrelated 32.768 khz crystal
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial
  begin
    crystalClk = 1'b0;
    forever #15259 crystalClk = ~crystalClk;
  end
  // noise pattern and square wave edge counter
  always @(posedge clk_sys)
  begin
    noise_ff <= noise_ff + 8'h5b;
    sqPrev_ff <= square_wave_out_ff;
    if (square_wave_out_ff !== sqPrev_ff) sqEdges++;
  end
  task automatic waitc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      error_cnt++;
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    i_host.latch(a);
    i_host.strobeRd(v);
  endtask
  task automatic w(input logic [7:0] a, input logic [7:0] v);
    i_host.wr(a, v, 1'b1);
  endtask
  task automatic sqCount(input int n, output int e);
    int s;
    s = sqEdges;
    waitc(n);
    e = sqEdges - s;
  endtask
  task automatic kick();
    kickstart_in_n <= 1'b0;
    waitc(8);
    kickstart_in_n <= 1'b1;
    waitc(8);
  endtask
  task automatic give_verdict();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic s_powerup();
    rd(8'h0a, d);
    check("divider bit", d & 8'h20, 8'h20);
    sqCount(2000, c);
    check("32k after power up", {7'h00, c >= 10}, 8'h01);
    w(8'h0a, 8'h30);
    rd(8'h4b, d);
    check("32k enable bit", d & 8'h40, 8'h40);
  endtask
  task automatic s_sqw();
    w(8'h4b, 8'h00);
    w(8'h0b, 8'h00);
    waitc(20);
    sqCount(1500, c);
    check("both enables off", c[7:0], 8'h00);
    w(8'h0b, 8'h08);
    w(8'h0a, 8'h33);
    waitc(700);
    sqCount(2500, c);
    check("rate 3 tap", {7'h00, c >= 3 && c <= 5}, 8'h01);
    w(8'h4b, 8'h40);
    sqCount(2000, c);
    check("32k overrides rate", {7'h00, c >= 10}, 8'h01);
  endtask
  task automatic s_bus();
    w(8'h21, 8'h3c);
    w(8'h20, 8'ha5);
    i_host.wr(8'h21, 8'hc3, 1'b0);
    rd(8'h21, d);
    check("write without select", d, 8'h3c);
    i_host.latch(8'h20);
    i_host.strobeRd(d);
    check("latch without select", d, 8'ha5);
    rd(8'h0d, d);
    check("unmapped read", d, 8'h00);
  endtask
  task automatic s_irq();
    w(8'h4a, 8'h04);
    kick();
    check("kick interrupt", {7'h00, irqOe_n_ff}, 8'h00);
    check("no power trigger", {7'h00, powerOnOe_n_ff}, 8'h01);
    w(8'h4a, 8'h04);
    waitc(6);
    check("flag cleared", {7'h00, irqOe_n_ff}, 8'h01);
    w(8'h4a, 8'h00);
    kick();
    check("masked flag", {7'h00, irqOe_n_ff}, 8'h01);
    w(8'h4a, 8'h80);
    waitc(6);
    check("power pin on", {7'h00, powerOnOe_n_ff}, 8'h00);
    w(8'h4a, 8'h00);
    waitc(6);
    check("power pin off", {7'h00, powerOnOe_n_ff}, 8'h01);
  endtask
  task automatic s_ramclr();
    w(8'h4a, 8'h10);
    w(8'h30, 8'h77);
    rd(8'h30, d);
    check("ram write", d, 8'h77);
    ram_clear_in_n <= 1'b0;
    waitc(6);
    ram_clear_in_n <= 1'b1;
    waitc(150);
    rd(8'h30, d);
    check("ram cleared", d, 8'h00);
    w(8'h4a, 8'h00);
  endtask
  // periodic flag is sticky since rate 3 ran; rate 0 stops new sets before the read
  task automatic s_periodic();
    w(8'h0b, 8'h40);
    waitc(1300);
    check("periodic interrupt", {7'h00, irqOe_n_ff}, 8'h00);
    w(8'h0a, 8'h30);
    rd(8'h0c, d);
    check("flags read", d, 8'hc0);
    waitc(4);
    check("flags read clears", {7'h00, irqOe_n_ff}, 8'h01);
    w(8'h0b, 8'h00);
  endtask
  task automatic s_battery();
    w(8'h4b, 8'hc0);
    w(8'h31, 8'h11);
    w(8'h0a, 8'h10);
    aux_battery_supply <= 1'b0;
    mainSupplyOk <= 1'b0;
    waitc(20);
    sqCount(1000, c);
    check("no aux no 32k", c[7:0], 8'h00);
    kick();
    check("kick needs aux", {7'h00, powerOnOe_n_ff}, 8'h01);
    i_host.wr(8'h31, 8'h55, 1'b1);
    aux_battery_supply <= 1'b1;
    waitc(10);
    sqCount(1000, c);
    check("aux 32k", {7'h00, c >= 5}, 8'h01);
    kick();
    check("kick power on", {7'h00, powerOnOe_n_ff}, 8'h00);
    mainSupplyOk <= 1'b1;
    waitc(40);
    rd(8'h31, d);
    check("write blocked", d, 8'h11);
    rd(8'h0a, d);
    check("divider after return", d & 8'h20, 8'h20);
  endtask
  // watchdog far beyond the expected run length
  initial
  begin
    #(60000 * 100);
    error_cnt++;
    give_verdict();
  end
  initial
  begin
    reset = 1'b1;
    mainSupplyOk = 1'b1;
    aux_battery_supply = 1'b1;
    kickstart_in_n = 1'b1;
    ram_clear_in_n = 1'b1;
    waitc(6);
    reset <= 1'b0;
    waitc(40);
    s_powerup();
    s_sqw();
    s_bus();
    s_irq();
    s_ramclr();
    s_periodic();
    s_battery();
    give_verdict();
  end
endmodule // tb_rtc_bus_pin_ctrl
`default_nettype wire
